// ===== tat_consts.svh
`ifndef TAT_CONSTS_SVH
`define TAT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------
`define TAT_OFF_CONTROL   8'h00
`define TAT_OFF_COUNT     8'h04
`define TAT_OFF_PERIOD    8'h08
`define TAT_OFF_STATUS    8'h0c

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define TAT_BIT_ON        15
`define TAT_BIT_IDLE      13
`define TAT_BIT_WBLOCK    12
`define TAT_BIT_WPEND     11
`define TAT_BIT_ECS_HI    9
`define TAT_BIT_ECS_LO    8
`define TAT_BIT_GATE      7
`define TAT_BIT_PS_HI     5
`define TAT_BIT_PS_LO     4
`define TAT_BIT_SYNC      2
`define TAT_BIT_CS        1
`define TAT_CTRL_MASK     32'h0000_bbb6

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define TAT_CTRL_RESET    32'h0000_0000
`define TAT_PERIOD_RESET  16'hffff
`define TAT_WRITE_XFER    3

`endif

// ===== tat_pkg.sv
package tat_pkg;

  // External clock source choices
  typedef enum logic [1:0] {
    TAT_SRC_SECONDARY = 2'h0,
    TAT_SRC_PIN       = 2'h1,
    TAT_SRC_LOW_POWER_RC_OSC      = 2'h2,
    TAT_SRC_RESERVED  = 2'h3
  } tat_src_t;

  // Asynchronous counter write transfer states (Gray from IDLE through LOAD to DONE)
  typedef enum logic [1:0] {
    TAT_WR_IDLE = 2'b00,
    TAT_WR_LOAD = 2'b01,
    TAT_WR_DONE = 2'b11
  } tat_wr_state_t;

endpackage

// ===== tat_prescaler.sv
`timescale 1ns/1ps
`include "tat_consts.svh"

// ----------------------------------------------------------------------
// Prescaler: divides count ticks by 1, 8, 64 or 256
// ----------------------------------------------------------------------
module tat_prescaler
  import tat_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  output logic            tick_out
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] limit;

  // Terminal count for each code
  always_comb begin
    case (sel)
      2'h0:    limit = WIDTH'(0);
      2'h1:    limit = WIDTH'(7);
      2'h2:    limit = WIDTH'(63);
      default: limit = WIDTH'(255);
    endcase
  end

  // Divider count; clear restarts the ratio cleanly
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= (cnt_q >= limit) ? '0 : cnt_q + WIDTH'(1);
    end
  end

  assign tick_out = tick && (cnt_q >= limit);

endmodule // tat_prescaler

// ===== tat_timer.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tat_consts.svh"

module tat_timer
  import tat_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        idle_mode,
  input  wire logic        secondary_osc,
  input  wire logic        timer_clock_pin,
  input  wire logic        low_power_rc_osc,
  input  wire logic        gate_in,
  output logic             period_match
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic             on_q;         // Enable
  logic             idle_stop_q;  // Halt while the device idles
  logic             blk_q;        // Refuse counter writes while pending
  logic             gate_q;       // Gated accumulation enable
  logic             sync_q;       // Resync the external clock
  logic             cs_q;         // External clock source
  logic [1:0]       ecs_q;
  logic [1:0]       ps_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] wval_q;
  tat_wr_state_t    wst_q;
  logic             match_q;

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  logic [2:0] s_secondary_osc_q;
  logic [2:0] s_pin_q;
  logic [2:0] s_low_power_rc_osc_q;
  logic [1:0] s_gate_q;
  logic       ext_rise;

  // Rising edge between the synchronised stage and its history stage
  function automatic logic src_rise(input logic [2:0] s);
    return s[1] && !s[2];
  endfunction

  // Two flops per pin; first stage feeds only the second, third is history
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_secondary_osc_q <= 3'h0;
      s_pin_q  <= 3'h0;
      s_low_power_rc_osc_q <= 3'h0;
      s_gate_q <= 2'h0;
    end else begin
      s_secondary_osc_q <= {s_secondary_osc_q[1:0], secondary_osc};
      s_pin_q  <= {s_pin_q[1:0], timer_clock_pin};
      s_low_power_rc_osc_q <= {s_low_power_rc_osc_q[1:0], low_power_rc_osc};
      s_gate_q <= {s_gate_q[0], gate_in};
    end
  end

  // Edges are taken per source before the mux: one shared history flop
  // would see a false edge when the select moves from a low source to a
  // high one. Reserved code gives no clock.
  always_comb begin
    case (tat_src_t'(ecs_q))
      TAT_SRC_SECONDARY: ext_rise = src_rise(s_secondary_osc_q);
      TAT_SRC_PIN:       ext_rise = src_rise(s_pin_q);
      TAT_SRC_LOW_POWER_RC_OSC:      ext_rise = src_rise(s_low_power_rc_osc_q);
      default:           ext_rise = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Count tick selection
  // --------------------------------------------------------------------
  logic run;
  logic raw_tick;
  logic ps_tick;
  logic async_mode;

  // Idle only stops the timer when the idle-stop bit asks for it
  // Idle is a same-clock level from the power manager, so no synchroniser
  assign run = on_q && !(idle_stop_q && idle_mode);

  // Bus clock with optional gate, or external edge; gate ignored if external
  // Gate is a pin level, so it is read only after its synchroniser
  always_comb begin
    if (!cs_q) begin
      raw_tick = gate_q ? s_gate_q[1] : 1'b1;
    end else begin
      raw_tick = ext_rise;
    end
  end

  // Async mode: external source without resync
  // In sync mode counter writes load at once and never pend
  assign async_mode = cs_q && !sync_q;

  // Stopping clears the divider so a restart gets a full first ratio
  tat_prescaler #(
    .WIDTH (8)
  ) u_ps (
    .mclk     (mclk),
    .reset    (reset),
    .clear    (!run),
    .tick     (run && raw_tick),
    .sel      (ps_q),
    .tick_out (ps_tick)
  );

  // --------------------------------------------------------------------
  // Register write decode
  // --------------------------------------------------------------------
  logic wr_ctrl;      // Control write this cycle
  logic wr_count;     // Counter write this cycle
  logic wr_period;    // Period write this cycle
  logic count_wr_ok;  // Counter write accepted

  // Address match against one register offset
  function automatic logic at_reg(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // One write strobe per writable register: control, count and period
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_count  = 1'b0;
    wr_period = 1'b0;
    if (reg_wr && at_reg(reg_addr, `TAT_OFF_CONTROL)) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && at_reg(reg_addr, `TAT_OFF_COUNT)) begin
      wr_count = 1'b1;
    end else if (reg_wr && at_reg(reg_addr, `TAT_OFF_PERIOD)) begin
      wr_period = 1'b1;
    end
  end

  // With the block bit set, blocked while a transfer pends; else a new write restarts it
  assign count_wr_ok = wr_count && !(blk_q && wst_q != TAT_WR_IDLE);

  // Control fields; unimplemented bits have no storage
  // Pending bit is read-only and has no write path
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      on_q        <= 1'b0;
      idle_stop_q <= 1'b0;
      blk_q       <= 1'b0;
      ecs_q       <= 2'h0;
      gate_q      <= 1'b0;
      ps_q        <= 2'h0;
      sync_q      <= 1'b0;
      cs_q        <= 1'b0;
    end else if (wr_ctrl) begin
      on_q        <= reg_wdata[`TAT_BIT_ON];
      idle_stop_q <= reg_wdata[`TAT_BIT_IDLE];
      blk_q       <= reg_wdata[`TAT_BIT_WBLOCK];
      ecs_q       <= reg_wdata[`TAT_BIT_ECS_HI:`TAT_BIT_ECS_LO];
      gate_q      <= reg_wdata[`TAT_BIT_GATE];
      ps_q        <= reg_wdata[`TAT_BIT_PS_HI:`TAT_BIT_PS_LO];
      sync_q      <= reg_wdata[`TAT_BIT_SYNC];
      cs_q        <= reg_wdata[`TAT_BIT_CS];
    end
  end

  // Period compare value; full scale after reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      period_q <= CNT_W'(`TAT_PERIOD_RESET);
    end else if (wr_period) begin
      period_q <= reg_wdata[CNT_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Counter write transfer
  // --------------------------------------------------------------------
  // In async mode a write lands only after three external rising edges, so the
  // loaded value does not race the counting edge.
  logic [1:0] xfer_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wst_q  <= TAT_WR_IDLE;
      wval_q <= '0;
      xfer_q <= 2'h0;
    end else if (count_wr_ok) begin
      wval_q <= reg_wdata[CNT_W-1:0];
      xfer_q <= 2'h0;
      wst_q  <= async_mode ? TAT_WR_LOAD : TAT_WR_IDLE;
    end else begin
      case (wst_q)
        TAT_WR_LOAD: begin
          if (ext_rise || !async_mode) begin
            xfer_q <= xfer_q + 2'h1;
            if (xfer_q == 2'(`TAT_WRITE_XFER - 1) || !async_mode) begin
              wst_q <= TAT_WR_DONE;
            end
          end
        end
        TAT_WR_DONE: begin
          wst_q <= TAT_WR_IDLE;
        end
        default: begin
          wst_q <= TAT_WR_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Counter and period match
  // --------------------------------------------------------------------
  // A landing write outranks counting; the tick of that cycle is lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
      match_q <= 1'b0;
    end else begin
      match_q <= 1'b0;
      if (count_wr_ok && !async_mode) begin
        count_q <= reg_wdata[CNT_W-1:0];
      end else if (wst_q == TAT_WR_DONE) begin
        count_q <= wval_q;
      end else if (ps_tick && wst_q == TAT_WR_IDLE) begin
        if (count_q == period_q) begin
          count_q <= '0;
          match_q <= 1'b1;
        end else begin
          count_q <= count_q + CNT_W'(1);
        end
      end
    end
  end

  // Registered pulse, one cycle per wrap
  assign period_match = match_q;

  // --------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------
  logic        pend;
  logic [31:0] ctrl_img;

  // Pending shows only in async mode, until the cycle after the load
  assign pend = async_mode && (wst_q != TAT_WR_IDLE);

  // Only implemented positions carry state
  always_comb begin
    ctrl_img                                 = `TAT_CTRL_RESET;
    ctrl_img[`TAT_BIT_ON]                    = on_q;
    ctrl_img[`TAT_BIT_IDLE]                  = idle_stop_q;
    ctrl_img[`TAT_BIT_WBLOCK]                = blk_q;
    ctrl_img[`TAT_BIT_WPEND]                 = pend;
    ctrl_img[`TAT_BIT_ECS_HI:`TAT_BIT_ECS_LO] = ecs_q;
    ctrl_img[`TAT_BIT_GATE]                  = gate_q;
    ctrl_img[`TAT_BIT_PS_HI:`TAT_BIT_PS_LO]  = ps_q;
    ctrl_img[`TAT_BIT_SYNC]                  = sync_q;
    ctrl_img[`TAT_BIT_CS]                    = cs_q;
    ctrl_img                                 = ctrl_img & `TAT_CTRL_MASK;
  end

  // Read data one cycle after the strobe; unmapped reads zero
  // Zero outside the answer cycle lets a bus OR several slaves together
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (at_reg(reg_addr, `TAT_OFF_CONTROL)) begin
        reg_rdata <= ctrl_img;
      end else if (at_reg(reg_addr, `TAT_OFF_COUNT)) begin
        reg_rdata <= 32'(count_q);
      end else if (at_reg(reg_addr, `TAT_OFF_PERIOD)) begin
        reg_rdata <= 32'(period_q);
      end else if (at_reg(reg_addr, `TAT_OFF_STATUS)) begin
        reg_rdata <= {30'h0, idle_mode, pend};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // tat_timer

// ===== tat_ext_osc.sv
`timescale 1ns/1ps

module tat_ext_osc #(
  parameter int HALF_SEC = 44,
  parameter int HALF_PIN = 200,
  parameter int HALF_RC  = 60
) (
  input  wire logic [2:0] run,
  output logic            secondary_osc,
  output logic            timer_clock_pin,
  output logic            low_power_rc_osc
);
  // ----------------------------------------------------------------------
  // Free sources; each freezes when its run bit drops
  // ----------------------------------------------------------------------
  logic sec_q = 1'b0;
  logic pin_q = 1'b0;
  logic rc_q  = 1'b0;
  // Half periods are whole multiples of the mclk half period, so every source is phase-locked to mclk
  always #(HALF_SEC) if (run[0]) sec_q = ~sec_q;
  always #(HALF_PIN) if (run[1]) pin_q = ~pin_q;
  always #(HALF_RC) if (run[2]) rc_q = ~rc_q;
  // One driver per output
  assign secondary_osc    = sec_q;
  assign timer_clock_pin  = pin_q;
  assign low_power_rc_osc = rc_q;
endmodule // tat_ext_osc

// ===== tat_timer_sva.sv
`timescale 1ns/1ps
`include "tat_consts.svh"

module tat_timer_sva
  import tat_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        idle_mode,
  input wire logic        gate_in,
  input wire logic        period_match
);
  // ----------------------------------------------------------------------
  // Shadow control word and stop-duration counter
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [3:0]  halt_q;
  logic        halt;
  logic        rd_ctl;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Every reason that must freeze the count
  assign halt = !ctrl_q[15] | (idle_mode & ctrl_q[13]) | (!ctrl_q[1] & ctrl_q[7] & !gate_in)
              | (ctrl_q[1] & (ctrl_q[9:8] == 2'h3));
  assign rd_ctl = reg_rd && (reg_addr == `TAT_OFF_CONTROL);
  // Mode tracking from software writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) ctrl_q <= 32'h0;
    else if (reg_wr && reg_addr == `TAT_OFF_CONTROL) ctrl_q <= reg_wdata & `TAT_CTRL_MASK;
  end
  // Saturates so long stops never wrap back below the limit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) halt_q <= 4'h0;
    else if (!halt) halt_q <= 4'h0;
    else if (halt_q != 4'hf) halt_q <= halt_q + 4'h1;
  end
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_ctrl_res; $past(rd_ctl) |-> (reg_rdata & ~`TAT_CTRL_MASK) == 32'h0; endproperty
  a_ctrl_res: assert property (p_ctrl_res) else $error("unused control bit set");
  property p_sync_pend0;
    $past(rd_ctl) && !($past(ctrl_q[1]) && !$past(ctrl_q[2])) |-> !reg_rdata[11];
  endproperty
  a_sync_pend0: assert property (p_sync_pend0) else $error("pending set in sync mode");
  property p_pend_set;
    $past(reg_wr && reg_addr == `TAT_OFF_COUNT && ctrl_q[15] && ctrl_q[1] && !ctrl_q[2], 3)
      && $past(rd_ctl) |-> reg_rdata[11];
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set after write");
  property p_off; halt_q >= 4'h6 && !ctrl_q[15] |-> !period_match; endproperty
  a_off: assert property (p_off) else $error("match while disabled");
  property p_idle; halt_q >= 4'h6 && idle_mode && ctrl_q[13] |-> !period_match; endproperty
  a_idle: assert property (p_idle) else $error("match in idle with stop");
  property p_gate; halt_q >= 4'h6 && !ctrl_q[1] && ctrl_q[7] |-> !period_match; endproperty
  a_gate: assert property (p_gate) else $error("match with gate low");
  property p_ecs3; halt_q >= 4'h6 && ctrl_q[1] && ctrl_q[9:8] == 2'h3 |-> !period_match; endproperty
  a_ecs3: assert property (p_ecs3) else $error("match on reserved source");
endmodule // tat_timer_sva

bind tat_timer tat_timer_sva #(.CNT_W(CNT_W)) i_tat_timer_sva (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .gate_in(gate_in),
  .period_match(period_match));

// ===== tat_timer_tb_top.sv
`timescale 1ns/1ps
`include "tat_consts.svh"

module tat_timer_tb_top;
  // ----------------------------------------------------------------------
  // Bench signals, clock and instances
  // ----------------------------------------------------------------------
  logic        mclk, reset, reg_wr, reg_rd, idle_mode, gate_in, period_match;
  logic        s_osc, p_pin, r_osc;
  logic [2:0]  run;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int          miscompares, n_compared, cyc, n;
  int          dv[4] = '{1, 8, 64, 256};
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  tat_timer #(.CNT_W(16)) i_tat_timer (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .idle_mode(idle_mode), .secondary_osc(s_osc), .timer_clock_pin(p_pin),
    .low_power_rc_osc(r_osc), .gate_in(gate_in), .period_match(period_match));
  tat_ext_osc i_tat_ext_osc (.run(run), .secondary_osc(s_osc), .timer_clock_pin(p_pin),
    .low_power_rc_osc(r_osc));
  // ----------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Cycles to the next match pulse, bounded
  task automatic wait_match(output int t);
    t = 0;
    do begin
      @(posedge mclk);
      #1 t++;
    end while (period_match !== 1'b1 && t < 3000);
  endtask
  // Let the pin clock finish a transfer, then park on the reserved source
  task automatic finish_xfer(input logic [31:0] stop_ctrl);
    run <= 3'h2;
    n = 0;
    do begin
      rd(`TAT_OFF_STATUS, rv);
      n++;
    end while (rv[0] !== 1'b0 && n < 400);
    chk("transfer done", 32'h1, {31'h0, n < 400});
    wr(`TAT_OFF_CONTROL, stop_ctrl);
    run <= 3'h0;
    rd(`TAT_OFF_COUNT, rv);
  endtask
  task automatic give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {reset, reg_wr, reg_rd, idle_mode, gate_in} = 5'h10;
    {reg_addr, reg_wdata, run} = '0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(`TAT_OFF_CONTROL, rv);
    chk("control reset", 32'h0, rv);
    rd(`TAT_OFF_PERIOD, rv);
    chk("period reset", 32'h0000_ffff, rv);
    wr(`TAT_OFF_CONTROL, 32'hffff_ffff);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, rv);
    chk("unmapped", 32'h0, rv);
    rd(`TAT_OFF_CONTROL, rv);
    chk("control image", 32'h0000_b3b6, rv);
    wr(`TAT_OFF_PERIOD, 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(`TAT_OFF_CONTROL, 32'h8000 | (c << 4));
      wait_match(n);
      wait_match(n);
      chk("match spacing", 4 * dv[c], n);
    end
    wr(`TAT_OFF_CONTROL, 32'h0);
    @(posedge mclk);
    wr(`TAT_OFF_PERIOD, 32'hffff);
    wr(`TAT_OFF_COUNT, 32'h0);
    idle_mode <= 1'b1;
    wr(`TAT_OFF_CONTROL, 32'h0000_a000);
    repeat (20) @(posedge mclk);
    rd(`TAT_OFF_COUNT, rv);
    chk("idle stopped", 32'h0, rv);
    wr(`TAT_OFF_CONTROL, 32'h0000_8000);
    repeat (20) @(posedge mclk);
    rd(`TAT_OFF_COUNT, rv);
    chk("idle running", 32'h1, {31'h0, rv >= 20 && rv <= 30});
    idle_mode <= 1'b0;
    // Gate low holds, gate high counts
    wr(`TAT_OFF_CONTROL, 32'h0);
    @(posedge mclk);
    wr(`TAT_OFF_COUNT, 32'h0);
    wr(`TAT_OFF_CONTROL, 32'h0000_8080);
    repeat (20) @(posedge mclk);
    rd(`TAT_OFF_COUNT, rv);
    chk("gate low", 32'h0, rv);
    gate_in <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(`TAT_OFF_COUNT, rv);
    chk("gate high", 32'h1, {31'h0, rv >= 15 && rv <= 30});
    gate_in <= 1'b0;
    // Each source alone, gate bit set but ignored; code 3 sees all three running
    for (int e = 0; e < 4; e++) begin
      wr(`TAT_OFF_CONTROL, 32'h0);
      @(posedge mclk);
      wr(`TAT_OFF_CONTROL, 32'h0000_8086 | (e << 8));
      wr(`TAT_OFF_COUNT, 32'h0);
      rd(`TAT_OFF_CONTROL, rv);
      chk("sync pending", 32'h0, {31'h0, rv[11]});
      run <= (e == 3) ? 3'h7 : ~(3'h1 << e);
      repeat (100) @(posedge mclk);
      rd(`TAT_OFF_COUNT, rv);
      chk("unselected", 32'h0, rv);
      if (e < 3) begin
        run <= 3'h1 << e;
        repeat (120) @(posedge mclk);
        rd(`TAT_OFF_COUNT, rv);
        chk("selected", 32'h1, {31'h0, rv != 32'h0});
      end
    end
    // Async writes with block set, then clear
    run <= 3'h0;
    wr(`TAT_OFF_CONTROL, 32'h0000_9102);
    wr(`TAT_OFF_COUNT, 32'h5);
    rd(`TAT_OFF_CONTROL, rv);
    chk("pending", 32'h1, {31'h0, rv[11]});
    wr(`TAT_OFF_COUNT, 32'h9);
    finish_xfer(32'h0000_9302);
    chk("blocked write", 32'h1, {31'h0, rv >= 5 && rv <= 6});
    wr(`TAT_OFF_CONTROL, 32'h0000_8102);
    wr(`TAT_OFF_COUNT, 32'h5);
    wr(`TAT_OFF_COUNT, 32'h9);
    finish_xfer(32'h0000_8302);
    chk("last write wins", 32'h1, {31'h0, rv >= 9 && rv <= 10});
    give_verdict();
  end
endmodule // tat_timer_tb_top
